//--- rtl/frsf_status.v
// Purpose: builds the remote input status word returned to the master station
// Assumes: drive status inputs and master request bits synchronous to clock_in
// Notes:   timing of stores and instructions is modelled by fixed counts
//
// Functional notes
// - forward-run flag is 1 only while the motor turns forward
// - reverse-run flag is 1 only while the motor turns in reverse
// - run-indication flag shows the function assigned to the run output terminal
// - at-speed flag is 1 when output frequency reaches set frequency
// - overload-warning flag is 1 while an overload alarm exists
// - frequency-detect and fault flags show their terminals' assigned functions
// - run, frequency-detect and fault functions are selectable, listed meanings default
// - at-speed and overload-warning flags cannot be reassigned
// - three general-purpose flags have no function until assigned
// - monitor flag sets after result words load, clears when request drops
// - volatile write done sets after RAM store, clears when request drops
// - persistent write done sets after RAM and NVM store, clears on drop
// - execution done sets after all instruction words, clears on drop
// - error flag sets when a drive fault trips a protective function
// - ready flag sets once initialisation completes after reset
// - ready flag clears whenever a drive fault trips protection
// - monitor result words refresh continuously while monitor request is 1
// - instruction words processed in order 2, 10, 12, 14, 16, 18
// - a failed instruction leaves a nonzero reply code, zero means success
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "frsf_regs.vh"
module frsf_status #(
    parameter INIT_CYCLES = `FRSF_INIT_CYCLES,
    parameter MON_WIDTH   = 16
) (
    input  wire                 clock_in,
    input  wire                 rst_b_in,
    // drive state
    input  wire                 motor_fwd_in,
    input  wire                 motor_rev_in,
    input  wire                 speed_reached_in,
    input  wire                 overload_alarm_in,
    input  wire                 freq_detect_terminal_in,
    input  wire                 fault_relay_terminal_in,
    input  wire                 protect_trip_in,
    input  wire [MON_WIDTH-1:0] monitor_value_in,
    input  wire [15:0]          remote_write_word_freq_in,
    input  wire [5:0]           instr_fail_in,
    // master request bits
    input  wire                 monitor_request_in,
    input  wire                 freq_write_volatile_req_in,
    input  wire                 freq_write_persistent_req_in,
    input  wire                 instr_exec_request_in,
    input  wire                 error_reset_request_in,
    // register port
    input  wire [3:0]           reg_addr_in,
    input  wire [31:0]          reg_wdata_in,
    input  wire                 reg_wr_in,
    input  wire                 reg_rd_in,
    output reg  [31:0]          reg_rdata_out,
    // status word, monitor result and drive reset
    output wire [31:0]          status_word_out,
    output reg  [MON_WIDTH-1:0] monitor_result_out,
    output reg                  drive_reset_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_DONE = 2'h2;
    reg  [23:0] sel_q;
    reg  [15:0] init_cnt_q;
    reg         ready_q;
    reg         error_q;
    reg         mon_flag_q;
    reg         fwv_done_q;
    reg         fwp_done_q;
    reg         exe_done_q;
    reg  [1:0]  exe_state_q;
    reg  [2:0]  word_idx_q;
    reg  [5:0]  reply_q;
    reg  [15:0] freq_ram_q;
    reg  [15:0] freq_nvm_q;
    reg  [15:0] mon_cnt_q;
    reg         fwv_req_q;
    reg         fwp_req_q;
    reg         exe_req_q;
    reg         rst_busy_q;
    reg  [7:0]  rst_cnt_q;
    wire        fwv_busy;
    wire        fwv_done;
    wire        fwp_busy;
    wire        fwp_done;
    wire        ins_done;
    wire        ins_start;
    wire        run_flag;
    wire        fdet_flag;
    wire        fault_flag;
    wire [2:0]  gp_flag;
    wire        fault_now;
    assign fault_now = protect_trip_in;

    // map instruction step to the word it handles (word 2, 10, 12, 14, 16, 18)
    function [4:0] frsf_word_num;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    frsf_word_num = 5'h02;
                3'h1:    frsf_word_num = 5'h0A;
                3'h2:    frsf_word_num = 5'h0C;
                3'h3:    frsf_word_num = 5'h0E;
                3'h4:    frsf_word_num = 5'h10;
                default: frsf_word_num = 5'h12;
            endcase
        end
    endfunction

    // assignable terminal flags; the select nibbles steer each one
    frsf_func_mux u_run_mux (
        .sel_in   (sel_q[3:0]),
        .run_in   (motor_fwd_in | motor_rev_in),
        .fdet_in  (freq_detect_terminal_in),
        .fault_in (fault_relay_terminal_in),
        .su_in    (speed_reached_in),
        .ol_in    (overload_alarm_in),
        .flag_out (run_flag)
    );
    frsf_func_mux u_fdet_mux (
        .sel_in   (sel_q[7:4]),
        .run_in   (motor_fwd_in | motor_rev_in),
        .fdet_in  (freq_detect_terminal_in),
        .fault_in (fault_relay_terminal_in),
        .su_in    (speed_reached_in),
        .ol_in    (overload_alarm_in),
        .flag_out (fdet_flag)
    );
    frsf_func_mux u_flt_mux (
        .sel_in   (sel_q[11:8]),
        .run_in   (motor_fwd_in | motor_rev_in),
        .fdet_in  (freq_detect_terminal_in),
        .fault_in (fault_relay_terminal_in),
        .su_in    (speed_reached_in),
        .ol_in    (overload_alarm_in),
        .flag_out (fault_flag)
    );

    // general-purpose flags default to no function
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_gp
            frsf_func_mux u_gp_mux (
                .sel_in   (sel_q[12+4*g+3:12+4*g]),
                .run_in   (motor_fwd_in | motor_rev_in),
                .fdet_in  (freq_detect_terminal_in),
                .fault_in (fault_relay_terminal_in),
                .su_in    (speed_reached_in),
                .ol_in    (overload_alarm_in),
                .flag_out (gp_flag[g])
            );
        end
    endgenerate

    // status word assembly; unlisted positions are tied low
    assign status_word_out = {4'h0,
                              ready_q,
                              error_q,
                              10'h000,
                              exe_done_q,
                              fwp_done_q,
                              fwv_done_q,
                              mon_flag_q,
                              gp_flag,
                              1'b0,
                              fault_flag,
                              fdet_flag,
                              1'b0,
                              overload_alarm_in,
                              speed_reached_in,
                              run_flag,
                              motor_rev_in & ~motor_fwd_in,
                              motor_fwd_in & ~motor_rev_in};

    // power-on initialisation then ready; a trip drops ready
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            init_cnt_q <= 16'h0000;
            ready_q    <= 1'b0;
        end else begin
            if (init_cnt_q < INIT_CYCLES[15:0]) begin
                init_cnt_q <= init_cnt_q + 16'h0001;
            end
            if (fault_now || error_q) begin
                ready_q <= 1'b0;
            end else if (init_cnt_q >= INIT_CYCLES[15:0] && !rst_busy_q) begin
                ready_q <= 1'b1;
            end
        end
    end

    // error flag and error reset sequence; a fresh trip beats the clear
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            error_q         <= 1'b0;
            rst_busy_q      <= 1'b0;
            rst_cnt_q       <= 8'h00;
            drive_reset_out <= 1'b0;
        end else begin
            drive_reset_out <= 1'b0;
            if (rst_busy_q) begin
                if (rst_cnt_q == 8'h00) begin
                    rst_busy_q <= 1'b0;
                    if (!fault_now) begin
                        error_q <= 1'b0;
                    end
                end else begin
                    rst_cnt_q <= rst_cnt_q - 8'h01;
                end
            end else if (error_q && error_reset_request_in) begin
                rst_busy_q      <= 1'b1;
                rst_cnt_q       <= `FRSF_RESET_CYCLES;
                drive_reset_out <= 1'b1;
            end
            if (fault_now) begin
                error_q <= 1'b1;
            end
        end
    end

    // monitor: refresh every cycle while requested, flag after first load
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            monitor_result_out <= {MON_WIDTH{1'b0}};
            mon_flag_q         <= 1'b0;
            mon_cnt_q          <= 16'h0000;
        end else if (monitor_request_in) begin
            monitor_result_out <= monitor_value_in;
            mon_flag_q         <= 1'b1;
            mon_cnt_q          <= mon_cnt_q + 16'h0001;
        end else begin
            mon_flag_q <= 1'b0;
        end
    end

    // request edge detectors for the write and execute handshakes
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            fwv_req_q <= 1'b0;
            fwp_req_q <= 1'b0;
            exe_req_q <= 1'b0;
        end else begin
            fwv_req_q <= freq_write_volatile_req_in;
            fwp_req_q <= freq_write_persistent_req_in;
            exe_req_q <= instr_exec_request_in;
        end
    end

    frsf_timer #(.WIDTH(8)) u_fwv_tmr (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .start_in (freq_write_volatile_req_in & ~fwv_req_q),
        .count_in (`FRSF_RAM_CYCLES),
        .busy_out (fwv_busy),
        .done_out (fwv_done)
    );
    frsf_timer #(.WIDTH(8)) u_fwp_tmr (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .start_in (freq_write_persistent_req_in & ~fwp_req_q),
        .count_in (`FRSF_NVM_CYCLES),
        .busy_out (fwp_busy),
        .done_out (fwp_done)
    );
    frsf_timer #(.WIDTH(8)) u_ins_tmr (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .start_in (ins_start),
        .count_in (`FRSF_INSTR_CYCLES),
        .busy_out (),
        .done_out (ins_done)
    );

    // frequency stores and their completion flags
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            freq_ram_q <= 16'h0000;
            freq_nvm_q <= 16'h0000;
            fwv_done_q <= 1'b0;
            fwp_done_q <= 1'b0;
        end else begin
            if (freq_write_volatile_req_in) begin
                freq_ram_q <= remote_write_word_freq_in; // volatile value follows request
            end
            if (!freq_write_volatile_req_in) begin
                fwv_done_q <= 1'b0;
            end else if (fwv_done && !fwv_busy) begin
                fwv_done_q <= 1'b1;
            end
            if (fwp_done && freq_write_persistent_req_in) begin
                freq_ram_q <= remote_write_word_freq_in;
                freq_nvm_q <= remote_write_word_freq_in;
            end
            if (!freq_write_persistent_req_in) begin
                fwp_done_q <= 1'b0;
            end else if (fwp_done && !fwp_busy) begin
                fwp_done_q <= 1'b1;
            end
        end
    end

    // instruction execution walks the six words in order
    assign ins_start = (exe_state_q == ST_IDLE && instr_exec_request_in && !exe_req_q) ||
                       (exe_state_q == ST_RUN && ins_done && word_idx_q != `FRSF_NUM_WORDS - 3'h1);
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            exe_state_q <= ST_IDLE;
            word_idx_q  <= 3'h0;
            reply_q     <= 6'h00;
            exe_done_q  <= 1'b0;
        end else begin
            case (exe_state_q)
                ST_IDLE: begin
                    exe_done_q <= 1'b0;
                    if (instr_exec_request_in && !exe_req_q) begin
                        exe_state_q <= ST_RUN;
                        word_idx_q  <= 3'h0;
                        reply_q     <= 6'h00;
                    end
                end
                ST_RUN: begin
                    if (ins_done) begin
                        reply_q[word_idx_q] <= instr_fail_in[word_idx_q];
                        if (word_idx_q == `FRSF_NUM_WORDS - 3'h1) begin
                            exe_state_q <= ST_DONE;
                        end else begin
                            word_idx_q <= word_idx_q + 3'h1;
                        end
                    end
                end
                ST_DONE: begin
                    exe_done_q <= instr_exec_request_in;
                    if (!instr_exec_request_in) begin
                        exe_state_q <= ST_IDLE;
                    end
                end
                default: exe_state_q <= ST_IDLE;
            endcase
        end
    end

    // select register write; at-speed and overload have no select field
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            sel_q <= `FRSF_SEL_RESET;
        end else if (reg_wr_in && reg_addr_in == `FRSF_ADDR_SEL) begin
            sel_q <= reg_wdata_in[23:0];
        end
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `FRSF_ADDR_STATUS: reg_rdata_out <= status_word_out;
                `FRSF_ADDR_SEL:    reg_rdata_out <= {8'h00, sel_q};
                `FRSF_ADDR_DRIVE:  reg_rdata_out <= {13'h0000, exe_state_q, word_idx_q,
                                                     frsf_word_num(word_idx_q), 9'h000};
                `FRSF_ADDR_REPLY:  reg_rdata_out <= {26'h0000000, reply_q};
                `FRSF_ADDR_FREQ:   reg_rdata_out <= {freq_nvm_q, freq_ram_q};
                `FRSF_ADDR_MONCNT: reg_rdata_out <= {16'h0000, mon_cnt_q};
                default:           reg_rdata_out <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end
endmodule // frsf_status

//--- rtl/frsf_regs.vh
// Purpose: constants for the remote status flag block
// Assumes: 40 MHz clock_in, status word 32 bits wide
// Notes:   bit positions follow the remote input word layout
`ifndef FRSF_REGS_VH
`define FRSF_REGS_VH
// register offsets on the plain port
`define FRSF_ADDR_STATUS   4'h0
`define FRSF_ADDR_SEL      4'h1
`define FRSF_ADDR_DRIVE    4'h2
`define FRSF_ADDR_REPLY    4'h3
`define FRSF_ADDR_FREQ     4'h4
`define FRSF_ADDR_MONCNT   4'h5
// status word bit positions
`define FRSF_BIT_FWD       0
`define FRSF_BIT_REV       1
`define FRSF_BIT_RUN       2
`define FRSF_BIT_SU        3
`define FRSF_BIT_OL        4
`define FRSF_BIT_FDET      6
`define FRSF_BIT_FLT       7
`define FRSF_BIT_GP0       9
`define FRSF_BIT_GP1       10
`define FRSF_BIT_GP2       11
`define FRSF_BIT_MON       12
`define FRSF_BIT_FWV       13
`define FRSF_BIT_FWP       14
`define FRSF_BIT_EXE       15
`define FRSF_BIT_ERR       26
`define FRSF_BIT_RDY       27
// function select codes (4 bits per assignable flag)
`define FRSF_FN_NONE       4'h0
`define FRSF_FN_RUN        4'h1
`define FRSF_FN_FDET       4'h2
`define FRSF_FN_FAULT      4'h3
`define FRSF_FN_SU         4'h4
`define FRSF_FN_OL         4'h5
// reset value of the select register: run, freq detect, fault, gp none
`define FRSF_SEL_RESET     24'h000321
// timing counts in clock_in cycles
`define FRSF_INIT_CYCLES   16'h0010
`define FRSF_RAM_CYCLES    8'h04
`define FRSF_NVM_CYCLES    8'h40
`define FRSF_INSTR_CYCLES  8'h08
`define FRSF_RESET_CYCLES  8'h20
`define FRSF_NUM_WORDS     3'h6
`endif

//--- rtl/frsf_func_mux.v
// Purpose: selects one drive signal for an assignable status flag
// Assumes: select codes from frsf_regs.vh
// Notes:   unknown codes give zero so unassigned flags stay low
`timescale 1ns/1ps
`include "frsf_regs.vh"
module frsf_func_mux (
    input  wire [3:0] sel_in,
    input  wire       run_in,
    input  wire       fdet_in,
    input  wire       fault_in,
    input  wire       su_in,
    input  wire       ol_in,
    output reg        flag_out
);
    // combinational pick of the assigned function
    always @* begin
        case (sel_in)
            `FRSF_FN_RUN:   flag_out = run_in;
            `FRSF_FN_FDET:  flag_out = fdet_in;
            `FRSF_FN_FAULT: flag_out = fault_in;
            `FRSF_FN_SU:    flag_out = su_in;
            `FRSF_FN_OL:    flag_out = ol_in;
            default:        flag_out = 1'b0;
        endcase
    end
endmodule // frsf_func_mux

//--- rtl/frsf_timer.v
// Purpose: one-shot busy timer for a handshake operation
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once when the count expires
`timescale 1ns/1ps
module frsf_timer #(
    parameter WIDTH = 8
) (
    input  wire             clock_in,
    input  wire             rst_b_in,
    input  wire             start_in,
    input  wire [WIDTH-1:0] count_in,
    output wire             busy_out,
    output reg              done_out
);
    reg [WIDTH-1:0] cnt_q;
    reg             busy_q;
    assign busy_out = busy_q;
    // load on start, count down, pulse done at one
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            cnt_q    <= {WIDTH{1'b0}};
            busy_q   <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_q  <= count_in;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_q   <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // frsf_timer

//--- verification/frsf_status_properties.sv
// Purpose: concurrent checks on the remote status word of frsf_status
// Assumes: one clock domain, synchronous active-low reset
// Notes:   direct flag bits are compared in the cycle their inputs change
`timescale 1ns/1ps
module frsf_status_properties (
    input wire        clock_in,
    input wire        rst_b_in,
    input wire        motor_fwd_in,
    input wire        motor_rev_in,
    input wire        speed_reached_in,
    input wire        overload_alarm_in,
    input wire        protect_trip_in,
    input wire [15:0] monitor_value_in,
    input wire        monitor_request_in,
    input wire        freq_write_volatile_req_in,
    input wire        freq_write_persistent_req_in,
    input wire        instr_exec_request_in,
    input wire        error_reset_request_in,
    input wire [31:0] status_word_out,
    input wire [15:0] monitor_result_out,
    input wire        drive_reset_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // positions with no meaning must never leak a value
    localparam [31:0] RSVD = 32'hF3FF0120;
    // direction and fixed flags, reserved positions
    AST_FWD: assert property (status_word_out[0] == (motor_fwd_in && !motor_rev_in))
        else $error("forward flag wrong");
    AST_REV: assert property (status_word_out[1] == (motor_rev_in && !motor_fwd_in))
        else $error("reverse flag wrong");
    AST_FIXED: assert property ({status_word_out[4], status_word_out[3]} == {overload_alarm_in, speed_reached_in})
        else $error("fixed flags wrong");
    AST_RSVD: assert property ((status_word_out & RSVD) == 32'h00000000)
        else $error("reserved bit set");
    // monitor handshake, result follows the source one cycle behind
    AST_MON_SET: assert property (monitor_request_in |=> status_word_out[12])
        else $error("monitor flag not set");
    AST_MON_CLR: assert property (!monitor_request_in |=> !status_word_out[12])
        else $error("monitor flag not cleared");
    AST_MON_FRESH: assert property (monitor_request_in |=> monitor_result_out == $past(monitor_value_in))
        else $error("monitor result stale");
    // store completions within a bounded time, volatile and exec done cleared after request drops
    AST_VOL: assert property ($rose(freq_write_volatile_req_in) |-> ##[1:12] (status_word_out[13] || !freq_write_volatile_req_in))
        else $error("volatile write done late");
    AST_VOL_CLR: assert property (!freq_write_volatile_req_in |=> !status_word_out[13])
        else $error("volatile done not cleared");
    AST_PERS: assert property ($rose(freq_write_persistent_req_in) |-> ##[1:100] (status_word_out[14] || !freq_write_persistent_req_in))
        else $error("persistent write done late");
    AST_EXE_CLR: assert property ($fell(instr_exec_request_in) |-> ##[1:2] !status_word_out[15])
        else $error("exec done not cleared");
    // protective trip
    AST_TRIP: assert property (protect_trip_in |=> status_word_out[26] && !status_word_out[27])
        else $error("trip not reflected");
    AST_ERST: assert property ($rose(error_reset_request_in) && status_word_out[26] |-> ##[0:3] drive_reset_out)
        else $error("no drive reset pulse");
    COV_MON: cover property (monitor_request_in ##1 status_word_out[12]);
    COV_EXE: cover property (instr_exec_request_in && status_word_out[15]);
    COV_ERST: cover property (drive_reset_out);
endmodule // frsf_status_properties

bind frsf_status frsf_status_properties u_props (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .motor_fwd_in(motor_fwd_in), .motor_rev_in(motor_rev_in),
    .speed_reached_in(speed_reached_in), .overload_alarm_in(overload_alarm_in), .protect_trip_in(protect_trip_in),
    .monitor_value_in(monitor_value_in), .monitor_request_in(monitor_request_in),
    .freq_write_volatile_req_in(freq_write_volatile_req_in),
    .freq_write_persistent_req_in(freq_write_persistent_req_in), .instr_exec_request_in(instr_exec_request_in),
    .error_reset_request_in(error_reset_request_in), .status_word_out(status_word_out),
    .monitor_result_out(monitor_result_out), .drive_reset_out(drive_reset_out)
);

//--- verification/frsf_master_model.sv
// Purpose: master station model raising request bits and awaiting flags
// Assumes: status word sampled just after each rising edge
// Notes:   one request at a time; a flag never seen counts as a failure
`timescale 1ns/1ps
module frsf_master_model (
    input  wire        clock_in,
    input  wire [31:0] status_in,
    output reg  [4:0]  req_out
);
    initial req_out = 5'h00;
    // raise request k, wait for bit b to reach lvl, then drop and see it clear
    task automatic handshake(input int k, input int b, input bit lvl, output bit ok);
        int n;
        bit gone;
        ok = 1'b0;
        gone = 1'b0;
        if (k < 4 && status_in[27] !== 1'b1) return;
        @(posedge clock_in);
        req_out[k] <= 1'b1;
        for (n = 0; n < 200 && !ok; n++) begin
            @(posedge clock_in);
            #1;
            ok = (status_in[b] === lvl);
        end
        @(posedge clock_in);
        req_out[k] <= 1'b0;
        // a done flag must fall again once the request is gone
        for (n = 0; n < 4 && lvl && !gone; n++) begin
            @(posedge clock_in);
            #1;
            gone = (status_in[b] === 1'b0);
        end
        ok = ok && (gone || !lvl);
    endtask
endmodule // frsf_master_model

//--- verification/fieldbus_remote_status_flags_tb.sv
// Purpose: self-checking bench for the remote status word block
// Assumes: register port reads answer in the following cycle
// Notes:   init count shortened to 4 cycles to keep the run brief
`timescale 1ns/1ps
module fieldbus_remote_status_flags_tb;
    localparam INIT = 4;
    reg         clock_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg  [5:0]  drv      = 6'h00;
    reg         trip     = 1'b0;
    reg  [15:0] mon_val  = 16'h0000;
    reg  [5:0]  fail     = 6'h00;
    reg  [3:0]  addr     = 4'h0;
    reg  [31:0] wdata    = 32'h00000000;
    reg         wr_s     = 1'b0;
    reg         rd_s     = 1'b0;
    wire [31:0] rdata;
    wire [31:0] status;
    wire [15:0] mres;
    wire        drst;
    wire [4:0]  req;
    logic [31:0] r;
    bit         ok;
    int         mismatches = 0;
    int         checks     = 0;
    int         i, n;

    always #12.5 clock_in = ~clock_in;
    // moving monitor source so stale results show
    always @(posedge clock_in) mon_val <= mon_val + 16'h0001;

    frsf_status #(.INIT_CYCLES(INIT), .MON_WIDTH(16)) DUT (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .motor_fwd_in(drv[0]), .motor_rev_in(drv[1]),
        .speed_reached_in(drv[2]), .overload_alarm_in(drv[3]), .freq_detect_terminal_in(drv[4]),
        .fault_relay_terminal_in(drv[5]), .protect_trip_in(trip), .monitor_value_in(mon_val),
        .remote_write_word_freq_in(16'h1234), .instr_fail_in(fail), .monitor_request_in(req[0]),
        .freq_write_volatile_req_in(req[1]), .freq_write_persistent_req_in(req[2]),
        .instr_exec_request_in(req[3]), .error_reset_request_in(req[4]), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .status_word_out(status), .monitor_result_out(mres), .drive_reset_out(drst));
    frsf_master_model mm (.clock_in(clock_in), .status_in(status), .req_out(req));

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_in);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock_in);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    // drive state: {fault term, fdet term, overload, at speed, rev, fwd}
    task set(input logic [5:0] v);
        @(posedge clock_in);
        drv <= v;
        @(posedge clock_in);
        #1;
    endtask
    task end_sim;
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        #1;
        chk("ready_early", 32'h0, {31'h0, status[27]});
        for (n = 0; n < 20 && status[27] !== 1'b1; n++) begin
            @(posedge clock_in);
            #1;
        end
        chk("ready_lat", 32'h1, {31'h0, n >= INIT - 1 && n <= INIT + 2});
        rd(4'h1, r);
        chk("sel_reset", 32'h00000321, r);
        rd(4'hF, r);
        chk("unmapped", 32'h0, r);
        // direction table with default assignments
        for (i = 0; i < 4; i++) begin
            set(i[5:0]);
            chk("dir", {29'h0, i != 0, i == 2, i == 1}, {29'h0, status[2:0]});
        end
        set(6'h3C);
        chk("defaults", 32'h0D8, {20'h0, status[11:0]});
        rd(4'h0, r);
        chk("status_rd", 32'h080000D8, r);
        // reassign: run none, fdet=run, fault=fdet, gp0=su, gp1=ol, gp2=fault
        wr(4'h1, 32'h00354210);
        rd(4'h1, r);
        chk("sel_wr", 32'h00354210, r);
        set(6'h01);
        chk("assign_a", 32'h041, {20'h0, status[11:0]});
        set(6'h3C);
        chk("assign_b", 32'hE98, {20'h0, status[11:0]});
        // handshakes driven by the master model
        mm.handshake(0, 12, 1'b1, ok);
        chk("hs_mon", 32'h1, {31'h0, ok});
        mm.handshake(1, 13, 1'b1, ok);
        chk("hs_vol", 32'h1, {31'h0, ok});
        mm.handshake(2, 14, 1'b1, ok);
        chk("hs_pers", 32'h1, {31'h0, ok});
        rd(4'h4, r);
        chk("freq_store", 32'h12341234, r);
        mm.handshake(3, 15, 1'b1, ok);
        chk("hs_exe", 32'h1, {31'h0, ok});
        rd(4'h2, r);
        chk("exe_last", 32'h00016400, r);
        rd(4'h3, r);
        chk("reply_ok", 32'h0, r);
        fail <= @(posedge clock_in) 6'h08;
        mm.handshake(3, 15, 1'b1, ok);
        chk("hs_exe_f", 32'h1, {31'h0, ok});
        rd(4'h3, r);
        chk("reply_fail", 32'h1, {31'h0, |r});
        // protective trip, then error reset once the trip has gone
        @(posedge clock_in);
        trip <= 1'b1;
        @(posedge clock_in);
        trip <= 1'b0;
        #1;
        chk("err_set", 32'h1, {31'h0, status[26]});
        chk("rdy_drop", 32'h0, {31'h0, status[27]});
        mm.handshake(4, 26, 1'b0, ok);
        chk("hs_erst", 32'h1, {31'h0, ok});
        repeat (2) @(posedge clock_in);
        #1;
        chk("rdy_back", 32'h1, {31'h0, status[27]});
        end_sim();
    end
endmodule // fieldbus_remote_status_flags_tb
